// >>> verilog/tbdc_pkg.sv
package tbdc_pkg;

   // special register numbers (10-bit)
   localparam logic [9:0] SPR_DOWN_COUNTER        = 10'h016;
   localparam logic [9:0] SPR_DOWN_COUNTER_RELOAD = 10'h036;
   localparam logic [9:0] SPR_TB_LOW_USER         = 10'h10C;
   localparam logic [9:0] SPR_TB_HIGH_USER        = 10'h10D;
   localparam logic [9:0] SPR_TB_LOW_SUPER        = 10'h11C;
   localparam logic [9:0] SPR_TB_HIGH_SUPER       = 10'h11D;
   localparam logic [9:0] SPR_TIMER_STATUS        = 10'h150;
   localparam logic [9:0] SPR_TIMER_CONTROL       = 10'h154;
   localparam logic [9:0] SPR_ALT_TB_LOWER        = 10'h20E;
   localparam logic [9:0] SPR_ALT_TB_UPPER        = 10'h20F;

   // timer control fields
   localparam int CTL_WD_SEL_LSB  = 0;
   localparam int CTL_FI_SEL_LSB  = 8;
   localparam int CTL_SEL_W       = 6;
   localparam int CTL_AUTO_RELOAD = 22;
   localparam int CTL_FI_IE       = 23;
   localparam int CTL_DOWN_IE     = 26;
   localparam int CTL_WD_IE       = 27;

   // timer status fields, written one to clear
   localparam int STS_DOWN_EVT  = 27;
   localparam int STS_FI_EVT    = 26;
   localparam int STS_WD_RESET  = 28;
   localparam int STS_WD_EVT    = 30;

   localparam logic [31:0] CTL_RESET = 32'h0000_0000;
   localparam logic [31:0] STS_RESET = 32'h0000_0000;
   localparam logic [31:0] DC_RESET  = 32'h0000_0000;

   // tick rates as divider counts of clk_sys
   localparam int TB_DIV_DEFAULT  = 8;
   localparam int ALT_DIV_DEFAULT = 1;

endpackage

// >>> verilog/tbdc_tick_div.sv
`timescale 1ns/1ps
module tbdc_tick_div #(
   parameter int DIV = 8
) (
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic sys_rst,
   // tick
   output logic      tick
);
   localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          tick;
   } tbdc_div_state_type;

   tbdc_div_state_type s_q;
   tbdc_div_state_type s_d;

   always_comb begin
      s_d      = s_q;
      s_d.tick = 1'b0;
      if (s_q.cnt == CW'(DIV - 1)) begin
         s_d.cnt  = '0;
         s_d.tick = 1'b1;
      end else begin
         s_d.cnt = s_q.cnt + CW'(1);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tick = s_q.tick;
endmodule

// >>> verilog/tbdc_timer.sv
`timescale 1ns/1ps
// Notes on behaviour
// - time base is high half over low half
// - both halves count as one 64-bit counter
// - user views read only, supervisor writes
// - time base bits trigger timer interrupts
// - down-counter steps with time base tick
// - down-counter interrupt when period elapses
// - auto-reload loads reload register value
// - control holds auto-reload and down interrupt enable
// - control selects any time base bit for triggers
// - status holds events and watchdog reset cause
// - watchdog and fixed-interval enables provided
// - alternate base read only, counts up, wraps
// - alternate base counts at its own rate
// - user time base at 268 and 269
// - supervisor time base at 284 and 285
// - down-counter at 22, reload at 54
// - control at 340, status at 336
// - alternate base at 526 and 527
module tbdc_timer #(
   parameter int TB_DIV  = tbdc_pkg::TB_DIV_DEFAULT,
   parameter int ALT_DIV = tbdc_pkg::ALT_DIV_DEFAULT
) (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   // special register port
   input  wire logic        spr_rd,
   input  wire logic        spr_wr,
   input  wire logic [9:0]  spr_num,
   input  wire logic        spr_super,
   input  wire logic [31:0] spr_wdata,
   output logic      [31:0] spr_rdata,
   output logic             spr_ack,
   output logic             spr_err,
   // reset cause from the reset logic
   input  wire logic        wd_reset_seen,
   // interrupt requests
   output logic             down_irq,
   output logic             fixed_irq,
   output logic             wd_irq
);
   typedef struct packed {
      logic [31:0] tb_hi;
      logic [31:0] tb_lo;
      logic [63:0] alt;
      logic [31:0] dc;
      logic [31:0] dc_reload;
      logic [31:0] ctl;
      logic [31:0] sts;
      logic        fi_bit_prev;
      logic        wd_bit_prev;
      logic        wd_cause_taken;
      logic [31:0] rdata;
      logic        ack;
      logic        err;
   } tbdc_state_type;

   tbdc_state_type s_q;
   tbdc_state_type s_d;
   logic           tb_tick;
   logic           alt_tick;

   tbdc_tick_div #(.DIV(TB_DIV)) u_tb_div (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .tick    (tb_tick)
   );

   tbdc_tick_div #(.DIV(ALT_DIV)) u_alt_div (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .tick    (alt_tick)
   );

   function automatic logic tb_bit_sel(input logic [63:0] tb, input logic [5:0] sel);
      tb_bit_sel = tb[sel];
   endfunction

   function automatic logic spr_known(input logic [9:0] n);
      case (n)
         tbdc_pkg::SPR_DOWN_COUNTER, tbdc_pkg::SPR_DOWN_COUNTER_RELOAD,
         tbdc_pkg::SPR_TB_LOW_USER, tbdc_pkg::SPR_TB_HIGH_USER,
         tbdc_pkg::SPR_TB_LOW_SUPER, tbdc_pkg::SPR_TB_HIGH_SUPER,
         tbdc_pkg::SPR_TIMER_STATUS, tbdc_pkg::SPR_TIMER_CONTROL,
         tbdc_pkg::SPR_ALT_TB_LOWER, tbdc_pkg::SPR_ALT_TB_UPPER: spr_known = 1'b1;
         default: spr_known = 1'b0;
      endcase
   endfunction

   logic [63:0] tb_now;
   logic [63:0] tb_inc;
   logic [5:0]  fi_sel;
   logic [5:0]  wd_sel;
   logic        fi_bit;
   logic        wd_bit;
   logic        wr_ok;
   logic        is_user_view;
   logic        is_super_only;

   always_comb begin
      tb_now        = {s_q.tb_hi, s_q.tb_lo};
      tb_inc        = tb_now + 64'h0000_0000_0000_0001;
      fi_sel        = s_q.ctl[tbdc_pkg::CTL_FI_SEL_LSB +: tbdc_pkg::CTL_SEL_W];
      wd_sel        = s_q.ctl[tbdc_pkg::CTL_WD_SEL_LSB +: tbdc_pkg::CTL_SEL_W];
      fi_bit        = tb_bit_sel(tb_now, fi_sel);
      wd_bit        = tb_bit_sel(tb_now, wd_sel);
      is_user_view  = (spr_num == tbdc_pkg::SPR_TB_LOW_USER)
                    || (spr_num == tbdc_pkg::SPR_TB_HIGH_USER)
                    || (spr_num == tbdc_pkg::SPR_ALT_TB_LOWER)
                    || (spr_num == tbdc_pkg::SPR_ALT_TB_UPPER);
      is_super_only = spr_known(spr_num) && !is_user_view;
      // user views take no write; supervisor registers need privilege
      wr_ok         = spr_wr && spr_super && is_super_only;
   end

   always_comb begin
      s_d     = s_q;
      s_d.ack = spr_rd || spr_wr;
      s_d.err = (spr_rd && (!spr_known(spr_num) || (is_super_only && !spr_super)))
             || (spr_wr && !wr_ok);

      // time base
      if (wr_ok && spr_num == tbdc_pkg::SPR_TB_LOW_SUPER) begin
         s_d.tb_lo = spr_wdata;
      end else if (wr_ok && spr_num == tbdc_pkg::SPR_TB_HIGH_SUPER) begin
         s_d.tb_hi = spr_wdata;
      end else if (tb_tick) begin
         s_d.tb_lo = tb_inc[31:0];
         s_d.tb_hi = tb_inc[63:32];
      end

      // alternate time base
      if (alt_tick) begin
         s_d.alt = s_q.alt + 64'h0000_0000_0000_0001;
      end

      // down-counter
      if (wr_ok && spr_num == tbdc_pkg::SPR_DOWN_COUNTER) begin
         s_d.dc = spr_wdata;
      end else if (tb_tick && s_q.dc != 32'h0000_0000) begin
         s_d.dc = s_q.dc - 32'h0000_0001;
      end else if (tb_tick && s_q.ctl[tbdc_pkg::CTL_AUTO_RELOAD]) begin
         s_d.dc = s_q.dc_reload;
      end
      if (wr_ok && spr_num == tbdc_pkg::SPR_DOWN_COUNTER_RELOAD) begin
         s_d.dc_reload = spr_wdata;
      end

      // control
      if (wr_ok && spr_num == tbdc_pkg::SPR_TIMER_CONTROL) begin
         s_d.ctl = spr_wdata;
      end

      // status: write one to clear, a same-cycle event wins
      if (wr_ok && spr_num == tbdc_pkg::SPR_TIMER_STATUS) begin
         s_d.sts = s_q.sts & ~spr_wdata;
      end
      if (tb_tick && s_q.dc == 32'h0000_0001) begin
         s_d.sts[tbdc_pkg::STS_DOWN_EVT] = 1'b1;
      end
      if (!s_q.fi_bit_prev && fi_bit) begin
         s_d.sts[tbdc_pkg::STS_FI_EVT] = 1'b1;
      end
      if (!s_q.wd_bit_prev && wd_bit) begin
         s_d.sts[tbdc_pkg::STS_WD_EVT] = 1'b1;
      end
      if (!s_q.wd_cause_taken) begin
         s_d.sts[tbdc_pkg::STS_WD_RESET] = wd_reset_seen;
         s_d.wd_cause_taken              = 1'b1;
      end
      s_d.fi_bit_prev = fi_bit;
      s_d.wd_bit_prev = wd_bit;

      // read data
      s_d.rdata = 32'h0000_0000;
      if (spr_rd && !s_d.err) begin
         case (spr_num)
            tbdc_pkg::SPR_TB_LOW_USER:         s_d.rdata = s_q.tb_lo;
            tbdc_pkg::SPR_TB_HIGH_USER:        s_d.rdata = s_q.tb_hi;
            tbdc_pkg::SPR_TB_LOW_SUPER:        s_d.rdata = s_q.tb_lo;
            tbdc_pkg::SPR_TB_HIGH_SUPER:       s_d.rdata = s_q.tb_hi;
            tbdc_pkg::SPR_DOWN_COUNTER:        s_d.rdata = s_q.dc;
            tbdc_pkg::SPR_DOWN_COUNTER_RELOAD: s_d.rdata = s_q.dc_reload;
            tbdc_pkg::SPR_TIMER_CONTROL:       s_d.rdata = s_q.ctl;
            tbdc_pkg::SPR_TIMER_STATUS:        s_d.rdata = s_q.sts;
            tbdc_pkg::SPR_ALT_TB_LOWER:        s_d.rdata = s_q.alt[31:0];
            tbdc_pkg::SPR_ALT_TB_UPPER:        s_d.rdata = s_q.alt[63:32];
            default:                           s_d.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         s_q           <= '0;
         s_q.dc        <= tbdc_pkg::DC_RESET;
         s_q.ctl       <= tbdc_pkg::CTL_RESET;
         s_q.sts       <= tbdc_pkg::STS_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   assign spr_rdata = s_q.rdata;
   assign spr_ack   = s_q.ack;
   assign spr_err   = s_q.err;
   assign down_irq  = s_q.sts[tbdc_pkg::STS_DOWN_EVT] && s_q.ctl[tbdc_pkg::CTL_DOWN_IE];
   assign fixed_irq = s_q.sts[tbdc_pkg::STS_FI_EVT] && s_q.ctl[tbdc_pkg::CTL_FI_IE];
   assign wd_irq    = s_q.sts[tbdc_pkg::STS_WD_EVT] && s_q.ctl[tbdc_pkg::CTL_WD_IE];
endmodule

// >>> sim/tbdc_timer_asserts.sv
`timescale 1ns/1ps
module tbdc_timer_chk (
   // clock and reset
   input wire logic        clk_sys,
   input wire logic        sys_rst,
   // register port
   input wire logic        spr_rd,
   input wire logic        spr_wr,
   input wire logic [9:0]  spr_num,
   input wire logic        spr_super,
   input wire logic [31:0] spr_rdata,
   input wire logic        spr_ack,
   input wire logic        spr_err
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   property p_ack; spr_rd || spr_wr |=> spr_ack; endproperty
   a_ack: assert property (p_ack) else $error("no ack");
   property p_idle; !(spr_rd || spr_wr) |=> !spr_ack && spr_rdata == 32'h0; endproperty
   a_idle: assert property (p_idle) else $error("stray answer");
   property p_user_wr; spr_wr && !spr_super |=> spr_err; endproperty
   a_user_wr: assert property (p_user_wr) else $error("user write taken");
   property p_ro_wr; spr_wr && spr_num[9:1] == 9'h086 |=> spr_err; endproperty
   a_ro_wr: assert property (p_ro_wr) else $error("user view written");
   property p_alt_wr; spr_wr && spr_num[9:1] == 9'h107 |=> spr_err; endproperty
   a_alt_wr: assert property (p_alt_wr) else $error("alt base written");
   property p_user_rd; spr_rd && !spr_super && spr_num == 10'h11C |=> spr_err; endproperty
   a_user_rd: assert property (p_user_rd) else $error("user read of super view");
   property p_ok_wr; spr_wr && spr_super && spr_num == 10'h016 |=> spr_ack && !spr_err;
   endproperty
   a_ok_wr: assert property (p_ok_wr) else $error("down counter write refused");
   property p_err_ack; spr_err |-> spr_ack; endproperty
   a_err_ack: assert property (p_err_ack) else $error("err without ack");
endmodule
bind tbdc_timer tbdc_timer_chk u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .spr_rd(spr_rd),
   .spr_wr(spr_wr), .spr_num(spr_num), .spr_super(spr_super), .spr_rdata(spr_rdata),
   .spr_ack(spr_ack), .spr_err(spr_err));

// >>> sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   logic        clk_sys, sys_rst, spr_rd, spr_wr, spr_super, wd_reset_seen;
   logic [9:0]  spr_num;
   logic [31:0] spr_wdata, spr_rdata, rd_v, rd_w;
   logic        spr_ack, spr_err, down_irq, e_v, fixed_irq, wd_irq;
   int          miscompares, tests_run;
   localparam logic [9:0] RO_NUM [4] = '{10'h10C, 10'h10D, 10'h20E, 10'h20F};

   tbdc_timer #(.TB_DIV(2), .ALT_DIV(1)) u_tbdc_timer (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .spr_rd(spr_rd), .spr_wr(spr_wr), .spr_num(spr_num), .spr_super(spr_super),
      .spr_wdata(spr_wdata), .spr_rdata(spr_rdata), .spr_ack(spr_ack), .spr_err(spr_err),
      .wd_reset_seen(wd_reset_seen), .down_irq(down_irq), .fixed_irq(fixed_irq),
      .wd_irq(wd_irq));

   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic test_done;
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // one access, answer sampled in the cycle after it is taken
   task automatic acc(input logic wr, input logic [9:0] num, input logic sup,
                      input logic [31:0] wd);
      @(negedge clk_sys);
      spr_rd = !wr;
      spr_wr = wr;
      spr_num = num;
      spr_super = sup;
      spr_wdata = wd;
      @(negedge clk_sys);
      spr_rd = 1'b0;
      spr_wr = 1'b0;
      chk("ack", 32'h1, {31'h0, spr_ack});
      rd_v = spr_rdata;
      e_v = spr_err;
   endtask

   task automatic wait_irq;
      for (int i = 0; i < 40 && down_irq !== 1'b1; i++) @(negedge clk_sys);
      chk("down irq", 32'h1, {31'h0, down_irq});
      if (down_irq !== 1'b1) test_done;
   endtask

   initial begin
      {sys_rst, wd_reset_seen} = 2'b11;
      {spr_rd, spr_wr, spr_super, spr_num, spr_wdata} = '0;
      miscompares = 0;
      tests_run = 0;
      repeat (8) @(negedge clk_sys);
      sys_rst = 1'b0;
      foreach (RO_NUM[i]) begin
         acc(1'b1, RO_NUM[i], 1'b1, 32'h1234_5678);
         chk("ro write", 32'h1, {31'h0, e_v});
      end
      acc(1'b1, 10'h016, 1'b0, 32'h5);
      chk("user write", 32'h1, {31'h0, e_v});
      acc(1'b0, 10'h11C, 1'b0, 32'h0);
      chk("user super read", 32'h1, {31'h0, e_v});
      acc(1'b0, 10'h3FF, 1'b1, 32'h0);
      chk("unknown", 32'h1, {31'h0, e_v});
      $display("test refusals done");
      acc(1'b1, 10'h036, 1'b1, 32'h4);
      acc(1'b0, 10'h036, 1'b1, 32'h0);
      chk("reload", 32'h4, rd_v);
      acc(1'b1, 10'h154, 1'b1, 32'h0400_0000);
      acc(1'b1, 10'h016, 1'b1, 32'h3);
      wait_irq;
      acc(1'b0, 10'h150, 1'b1, 32'h0);
      chk("down evt", 32'h0800_0000, rd_v & 32'h0800_0000);
      chk("wd cause", 32'h1000_0000, rd_v & 32'h1000_0000);
      acc(1'b1, 10'h150, 1'b1, 32'h0800_0000);
      acc(1'b0, 10'h016, 1'b1, 32'h0);
      chk("stopped", 32'h0, rd_v);
      chk("irq clear", 32'h0, {31'h0, down_irq});
      acc(1'b1, 10'h154, 1'b1, 32'h0440_0000);
      acc(1'b1, 10'h016, 1'b1, 32'h1);
      wait_irq;
      repeat (4) @(negedge clk_sys);
      acc(1'b0, 10'h016, 1'b1, 32'h0);
      chk("reloaded", 32'h1, {31'h0, rd_v != 0 && rd_v <= 4});
      acc(1'b0, 10'h154, 1'b1, 32'h0);
      chk("control", 32'h0440_0000, rd_v);
      $display("test down counter done");
      acc(1'b1, 10'h11D, 1'b1, 32'h5);
      acc(1'b1, 10'h11C, 1'b1, 32'hFFFF_FFFE);
      repeat (10) @(negedge clk_sys);
      acc(1'b0, 10'h10D, 1'b0, 32'h0);
      chk("tb carry", 32'h6, rd_v);
      acc(1'b0, 10'h20E, 1'b0, 32'h0);
      rd_w = rd_v;
      acc(1'b0, 10'h20E, 1'b0, 32'h0);
      chk("alt step", 32'h2, rd_v - rd_w);
      $display("test time bases done");
      // bit 0 selected for both triggers, so events keep being set
      acc(1'b1, 10'h154, 1'b1, 32'h0880_0000);
      chk("fixed irq", 32'h1, {31'h0, fixed_irq});
      chk("wd irq", 32'h1, {31'h0, wd_irq});
      acc(1'b1, 10'h154, 1'b1, 32'h0000_0000);
      chk("fixed irq off", 32'h0, {31'h0, fixed_irq});
      chk("wd irq off", 32'h0, {31'h0, wd_irq});
      $display("test interval enables done");
      // second reset, this time not caused by the watchdog
      @(negedge clk_sys);
      sys_rst = 1'b1;
      wd_reset_seen = 1'b0;
      repeat (2) @(negedge clk_sys);
      sys_rst = 1'b0;
      acc(1'b0, 10'h150, 1'b1, 32'h0);
      chk("wd cause clear", 32'h0, rd_v & 32'h1000_0000);
      $display("test reset cause done");
      test_done;
   end
endmodule
